// ### core/rfpd_pkg.sv
package rfpd_pkg;
  // Field geometry
  localparam int FIELD_BYTES = 64;
  localparam int FIELD_W = 512;
  localparam int DATA_W = 480;
  localparam int WORD_BITS = 32;
  localparam logic [6:0] MIN_BYTES = 7'h08;
  localparam logic [6:0] STEP_BYTES = 7'h04;
  localparam logic [6:0] MAX_BYTES = 7'h40;
  localparam logic [6:0] RO_OUT_BYTES = 7'h04;
  localparam logic [2:0] SIZE_MAX_CODE = 3'h7;
  localparam int WORD_SHIFT = 2;

  // Command and response byte positions
  localparam int CMD_BYTE = 0;
  localparam int PARAM_BYTE = 1;
  localparam int STATUS_BYTE = 2;
  localparam int CNT_BYTE = 3;
  localparam int DATA_BYTE = 4;
  localparam int TOGGLE_BIT = 7;
  localparam logic [7:0] STATUS_BUSY = 8'hFF;
  localparam logic [7:0] CNT_INIT = 8'h00;
  localparam logic [7:0] CNT_LAST = 8'hFF;
  localparam logic [7:0] CNT_WRAP = 8'h01;

  // Hold timer
  localparam int HOLD_STEP_MS = 10;
  localparam int CLK_HZ = 25000000;
  localparam int HOLD_STEP_CYC = (CLK_HZ / 1000) * HOLD_STEP_MS;
  localparam int HOLD_TICK_W = 18;
  localparam int HOLD_BAD_BIT = 2;

  // Diagnostic frame layout
  localparam int STD_HDR_BYTES = 6;
  localparam int DEV_DIAG_BYTES = 42;
  localparam int DIAG_W = (STD_HDR_BYTES + DEV_DIAG_BYTES) * 8;
  localparam int DEV_W = DEV_DIAG_BYTES * 8;
  localparam logic [7:0] DEV_DIAG_HDR = 8'h2A;
  localparam int DG_HDR = 0;
  localparam int DG_FAULT = 1;
  localparam int DG_CTRL_ID = 3;
  localparam int DG_CTRL_SW = 4;
  localparam int DG_CTRL_DATE = 7;
  localparam int DG_RSVD = 13;
  localparam int DG_RSVD_BYTES = 9;
  localparam int DG_HEAD_BASE = 22;
  localparam int DG_HEAD_STRIDE = 10;
  localparam int DG_HEAD_SW = 1;
  localparam int DG_HEAD_DATE = 4;
  localparam int NUM_HEADS = 2;
  localparam logic [7:0] ASCII_ZERO = 8'h30;

  // Fault word
  localparam logic [15:0] FLT_MASK = 16'h6177;
  localparam logic [15:0] FLT_RST = 16'h0100;
endpackage

// ### core/rfpd_hold_timer.sv
`timescale 1ns/1ps
module rfpd_hold_timer #(
  parameter int STEP_CYC = rfpd_pkg::HOLD_STEP_CYC
) (
  // Clock and synchronised reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic start_i,
  input wire logic [7:0] code_i,
  // Status
  output logic busy_o
);
  logic [7:0] unit_r;                          // Remaining 10 ms units
  logic [7:0] unit_nxt;
  logic [rfpd_pkg::HOLD_TICK_W-1:0] tick_r;    // Cycles within one unit
  logic [rfpd_pkg::HOLD_TICK_W-1:0] tick_nxt;
  localparam logic [rfpd_pkg::HOLD_TICK_W-1:0] TICK_TOP = rfpd_pkg::HOLD_TICK_W'(STEP_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // Count down the configured number of units after each load
  always_comb begin
    unit_nxt = unit_r;
    tick_nxt = tick_r;
    if (start_i) begin
      // Reload on each new write of the input field
      unit_nxt = code_i;
      tick_nxt = '0;
    end else if (unit_r != 8'h00) begin
      if (tick_r == TICK_TOP) begin
        tick_nxt = '0;
        unit_nxt = unit_r - 8'h01;
      end else begin
        tick_nxt = tick_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unit_r <= 8'h00;
      tick_r <= '0;
    end else begin
      unit_r <= unit_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Busy while units remain
  assign busy_o = (unit_r != 8'h00);
endmodule

// ### core/rfpd_core.sv
`timescale 1ns/1ps
// Summary of operation
// - Read/write modules: equal fields, 8..32 or 64
// - Read-only: input 8..32 or 64, output 4
// - Every data word is 32 bits
// - Input field held for hold time
// - Hold time in 10 ms steps, default zero
// - Diagnostic interrupt only when enabled
// - Diagnostic frame bytes 0 to 21 layout
// - Head data from byte 22 onward
// - Six-byte header plus 42 diagnostic bytes
// - Fault bits for errors and head state
// - Fault bits for resets, rest reserved
// - Controller id is ASCII head count
// - Response: echo, param, toggle, status, counter, data
// - Output field byte layout
// - Unused fields are ignored
// - New command only when content changes
// - Status FFh on detection, then final
// - Reply counter from 00h, wraps to 01h
module rfpd_core #(
  parameter int HOLD_STEP_CYC = rfpd_pkg::HOLD_STEP_CYC,
  parameter logic [3:0] CTRL_HEADS = 4'h2,     // Connectable heads
  parameter logic [23:0] CTRL_SW_NUM = 24'h000000, // Arbitrary value
  parameter logic [47:0] CTRL_DATE = 48'h000000000000 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Module selection and parameters
  input wire logic rw_mode_i,
  input wire logic [2:0] size_code_i,
  input wire logic [7:0] hold_code_i,
  input wire logic diag_irq_en_i,
  // Output field from master
  input wire logic out_valid_i,
  input wire logic [rfpd_pkg::FIELD_W-1:0] out_field_i,
  // Command to processing core
  output logic cmd_new_o,
  output logic [7:0] cmd_code_o,
  output logic [23:0] cmd_param_o,
  output logic [rfpd_pkg::DATA_W-1:0] cmd_data_o,
  output logic [3:0] cmd_words_o,
  // Response from processing core
  input wire logic resp_valid_i,
  output logic resp_ready_o,
  input wire logic [7:0] resp_param_i,
  input wire logic [7:0] resp_status_i,
  input wire logic [rfpd_pkg::DATA_W-1:0] resp_data_i,
  // Input field to master
  output logic [rfpd_pkg::FIELD_W-1:0] in_field_o,
  output logic data_exch_o,
  // Diagnostics
  input wire logic [15:0] fault_evt_i,
  input wire logic diag_read_i,
  input wire logic [47:0] std_hdr_i,
  input wire logic [rfpd_pkg::NUM_HEADS*8-1:0] head_id_i,
  input wire logic [rfpd_pkg::NUM_HEADS*24-1:0] head_sw_i,
  input wire logic [rfpd_pkg::NUM_HEADS*48-1:0] head_date_i,
  output logic [rfpd_pkg::DIAG_W-1:0] diag_frame_o,
  output logic diag_irq_o
);
  ////////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  logic [1:0] rst_sync_r; // Two-stage release
  logic rst_n;            // Synchronised reset

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // Field sizes from module selection
  logic [6:0] in_len;  // Input field bytes
  logic [6:0] out_len; // Output field bytes
  logic [rfpd_pkg::FIELD_W-1:0] out_mask;
  logic [rfpd_pkg::FIELD_W-1:0] in_mask;

  always_comb begin
    if (size_code_i == rfpd_pkg::SIZE_MAX_CODE) begin
      in_len = rfpd_pkg::MAX_BYTES;
    end else begin
      in_len = 7'(rfpd_pkg::MIN_BYTES + rfpd_pkg::STEP_BYTES * {4'h0, size_code_i});
    end
    // Read-only modules carry a fixed short output field
    out_len = rw_mode_i ? in_len : rfpd_pkg::RO_OUT_BYTES;
  end

  // Byte lane enables for the selected module
  for (genvar gb = 0; gb < rfpd_pkg::FIELD_BYTES; gb++) begin : g_lane
    assign out_mask[8*gb +: 8] = (7'(gb) < out_len) ? 8'hFF : 8'h00;
    assign in_mask[8*gb +: 8] = (7'(gb) < in_len) ? 8'hFF : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Command detection
  logic [rfpd_pkg::FIELD_W-1:0] out_seen;  // Masked output field
  logic [rfpd_pkg::FIELD_W-1:0] last_r;    // Last content read in
  logic [rfpd_pkg::FIELD_W-1:0] last_nxt;
  logic cmd_new_r, cmd_new_nxt;
  logic [7:0] cmd_code_r, cmd_code_nxt;
  logic [23:0] cmd_param_r, cmd_param_nxt;
  logic [rfpd_pkg::DATA_W-1:0] cmd_data_r, cmd_data_nxt;
  logic [3:0] cmd_words_r, cmd_words_nxt;
  logic ack_pend_r, ack_pend_nxt;          // FFh status still to post
  logic data_exch_r, data_exch_nxt;
  logic new_cmd;
  logic ack_clr;                           // Busy notice posted this cycle

  assign out_seen = out_field_i & out_mask;
  // A repeat needs an inverted toggle, otherwise content is unchanged
  assign new_cmd = out_valid_i && data_exch_r && (out_seen != last_r);

  always_comb begin
    last_nxt = last_r;
    cmd_new_nxt = 1'b0;
    cmd_code_nxt = cmd_code_r;
    cmd_param_nxt = cmd_param_r;
    cmd_data_nxt = cmd_data_r;
    cmd_words_nxt = cmd_words_r;
    ack_pend_nxt = ack_pend_r;
    // A hold code with bit 2 set keeps the slave out of data exchange
    data_exch_nxt = !hold_code_i[rfpd_pkg::HOLD_BAD_BIT];
    if (new_cmd) begin
      last_nxt = out_seen;
      cmd_new_nxt = 1'b1;
      // Code, parameters with toggle, then write data
      cmd_code_nxt = out_seen[8*rfpd_pkg::CMD_BYTE +: 8];
      cmd_param_nxt = out_seen[8*rfpd_pkg::PARAM_BYTE +: 24];
      cmd_data_nxt = out_seen[8*rfpd_pkg::DATA_BYTE +: rfpd_pkg::DATA_W];
      // Whole 32-bit words after the four header bytes
      cmd_words_nxt = 4'((out_len - rfpd_pkg::RO_OUT_BYTES) >> rfpd_pkg::WORD_SHIFT);
      ack_pend_nxt = 1'b1;
    end else if (ack_clr) begin
      ack_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      last_r <= '0;
      cmd_new_r <= 1'b0;
      cmd_code_r <= 8'h00;
      cmd_param_r <= 24'h000000;
      cmd_data_r <= '0;
      cmd_words_r <= 4'h0;
      ack_pend_r <= 1'b0;
      data_exch_r <= 1'b0;
    end else begin
      last_r <= last_nxt;
      cmd_new_r <= cmd_new_nxt;
      cmd_code_r <= cmd_code_nxt;
      cmd_param_r <= cmd_param_nxt;
      cmd_data_r <= cmd_data_nxt;
      cmd_words_r <= cmd_words_nxt;
      ack_pend_r <= ack_pend_nxt;
      data_exch_r <= data_exch_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input field update under the hold timer
  logic [rfpd_pkg::FIELD_W-1:0] in_r, in_nxt;
  logic [7:0] cnt_r, cnt_nxt;              // Reply counter
  logic ready_r, ready_nxt;
  logic hold_busy;
  logic resp_take;
  logic upd;

  assign resp_take = resp_valid_i && ready_r;
  // Busy-status posting waits for the hold time too
  assign ack_clr = ack_pend_r && !hold_busy && !resp_take;
  assign upd = resp_take || ack_clr;

  always_comb begin
    in_nxt = in_r;
    cnt_nxt = cnt_r;
    if (upd) begin
      // Every change of the input field advances the counter, skipping zero
      cnt_nxt = (cnt_r == rfpd_pkg::CNT_LAST) ? rfpd_pkg::CNT_WRAP : cnt_r + 8'h01;
      in_nxt[8*rfpd_pkg::CNT_BYTE +: 8] = cnt_nxt;
      in_nxt[8*rfpd_pkg::CMD_BYTE +: 8] = cmd_code_r;
      if (resp_take) begin
        // Final answer with toggle copied from the command
        in_nxt[8*rfpd_pkg::PARAM_BYTE +: 8] = {cmd_param_r[rfpd_pkg::TOGGLE_BIT], resp_param_i[6:0]};
        in_nxt[8*rfpd_pkg::STATUS_BYTE +: 8] = resp_status_i;
        in_nxt[8*rfpd_pkg::DATA_BYTE +: rfpd_pkg::DATA_W] =
          resp_data_i & in_mask[8*rfpd_pkg::DATA_BYTE +: rfpd_pkg::DATA_W];
      end else begin
        // Detection notice echoes the second command byte
        in_nxt[8*rfpd_pkg::PARAM_BYTE +: 8] = cmd_param_r[7:0];
        in_nxt[8*rfpd_pkg::STATUS_BYTE +: 8] = rfpd_pkg::STATUS_BUSY;
      end
    end
    // No response taken in the cycle after an update or while held
    ready_nxt = !upd && !hold_busy && !ack_pend_nxt && data_exch_r;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      in_r <= '0;
      cnt_r <= rfpd_pkg::CNT_INIT;
      ready_r <= 1'b0;
    end else begin
      in_r <= in_nxt;
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  // Hold timer, restarted by every write of the input field
  rfpd_hold_timer #(
    .STEP_CYC(HOLD_STEP_CYC)
  ) u_hold (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .start_i(upd),
    .code_i(hold_code_i),
    .busy_o(hold_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // Fault word and diagnostic interrupt
  logic [15:0] fault_r, fault_nxt;
  logic [15:0] fault_new;
  logic irq_r, irq_nxt;

  // Only documented fault bits can rise; reserved ones stay zero
  assign fault_new = fault_evt_i & rfpd_pkg::FLT_MASK & ~fault_r;

  always_comb begin
    fault_nxt = fault_r;
    if (diag_read_i) begin
      fault_nxt = 16'h0000;
    end
    // A fresh event wins over the read-clear
    fault_nxt = fault_nxt | (fault_evt_i & rfpd_pkg::FLT_MASK);
    irq_nxt = diag_irq_en_i && (fault_new != 16'h0000);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= rfpd_pkg::FLT_RST;
      irq_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Device-related diagnostic frame
  logic [rfpd_pkg::DEV_W-1:0] heads_w; // Head blocks in place
  logic [rfpd_pkg::DIAG_W-1:0] diag_r, diag_nxt;

  for (genvar gh = 0; gh < rfpd_pkg::NUM_HEADS; gh++) begin : g_head
    localparam int HB = rfpd_pkg::DG_HEAD_BASE + gh * rfpd_pkg::DG_HEAD_STRIDE;
    assign heads_w[8*HB +: 8] = head_id_i[8*gh +: 8];
    assign heads_w[8*(HB + rfpd_pkg::DG_HEAD_SW) +: 24] = head_sw_i[24*gh +: 24];
    assign heads_w[8*(HB + rfpd_pkg::DG_HEAD_DATE) +: 48] = head_date_i[48*gh +: 48];
  end
  assign heads_w[8*rfpd_pkg::DG_HEAD_BASE-1:0] = '0;

  always_comb begin
    diag_nxt = '0;
    diag_nxt[47:0] = std_hdr_i;
    // Device part sits after the standard header
    diag_nxt[rfpd_pkg::DIAG_W-1:8*rfpd_pkg::STD_HDR_BYTES] = heads_w;
    diag_nxt[8*(rfpd_pkg::STD_HDR_BYTES + rfpd_pkg::DG_HDR) +: 8] = rfpd_pkg::DEV_DIAG_HDR;
    diag_nxt[8*(rfpd_pkg::STD_HDR_BYTES + rfpd_pkg::DG_FAULT) +: 16] = {fault_r[7:0], fault_r[15:8]};
    diag_nxt[8*(rfpd_pkg::STD_HDR_BYTES + rfpd_pkg::DG_CTRL_ID) +: 8] =
      rfpd_pkg::ASCII_ZERO + {4'h0, CTRL_HEADS};
    diag_nxt[8*(rfpd_pkg::STD_HDR_BYTES + rfpd_pkg::DG_CTRL_SW) +: 24] = CTRL_SW_NUM;
    diag_nxt[8*(rfpd_pkg::STD_HDR_BYTES + rfpd_pkg::DG_CTRL_DATE) +: 48] = CTRL_DATE;
    diag_nxt[8*(rfpd_pkg::STD_HDR_BYTES + rfpd_pkg::DG_RSVD) +: 8*rfpd_pkg::DG_RSVD_BYTES] = '0;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      diag_r <= '0;
    end else begin
      diag_r <= diag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cmd_new_o = cmd_new_r;
  assign cmd_code_o = cmd_code_r;
  assign cmd_param_o = cmd_param_r;
  assign cmd_data_o = cmd_data_r;
  assign cmd_words_o = cmd_words_r;
  assign resp_ready_o = ready_r;
  assign in_field_o = in_r;
  assign data_exch_o = data_exch_r;
  assign diag_frame_o = diag_r;
  assign diag_irq_o = irq_r;
endmodule

// ### sim/rfpd_core_checker.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Port-level checker for the core
module rfpd_core_checker #(
  parameter int HOLD_STEP_CYC = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Settings and fields
  input wire logic [7:0] hold_code_i,
  input wire logic diag_irq_en_i,
  input wire logic out_valid_i,
  input wire logic [511:0] out_field_i,
  input wire logic cmd_new_o,
  input wire logic [7:0] cmd_code_o,
  input wire logic resp_valid_i,
  input wire logic resp_ready_o,
  input wire logic [7:0] resp_status_i,
  input wire logic [511:0] in_field_o,
  input wire logic data_exch_o,
  // Diagnostics
  input wire logic [383:0] diag_frame_o,
  input wire logic diag_irq_o
);
  logic [2:0] up_r, up_nxt; // Edges since reset release
  logic [15:0] gap_r, gap_nxt; // Cycles since last field change
  logic [511:0] prev_r; // Input field one cycle back
  logic chg; // Input field changed this cycle
  assign chg = in_field_o != prev_r;
  // Saturating counters
  always_comb begin
    up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
    gap_nxt = chg ? 16'h1 : ((gap_r == 16'hFFFF) ? gap_r : gap_r + 16'h1);
  end
  // Register the helpers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      up_r <= 3'h0;
      gap_r <= 16'hFFFF;
      prev_r <= '0;
    end else begin
      up_r <= up_nxt;
      gap_r <= gap_nxt;
      prev_r <= in_field_o;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_new_cause; cmd_new_o |-> $past(out_valid_i) && $past(data_exch_o); endproperty
  a_new_cause: assert property (p_new_cause) else $error("command without valid field");
  property p_code; cmd_new_o |-> cmd_code_o == $past(out_field_i[7:0]); endproperty
  a_code: assert property (p_code) else $error("command code not from byte 0");
  property p_count; chg |-> in_field_o[31:24] == ((prev_r[31:24] == 8'hFF) ? 8'h01 : prev_r[31:24] + 8'h01);
  endproperty
  a_count: assert property (p_count) else $error("reply counter step wrong");
  property p_hold; chg |-> gap_r >= 16'(hold_code_i) * 16'(HOLD_STEP_CYC); endproperty
  a_hold: assert property (p_hold) else $error("input field overwritten early");
  property p_resp; resp_valid_i && resp_ready_o |=> in_field_o[23:16] == $past(resp_status_i)
    && in_field_o[7:0] == cmd_code_o; endproperty
  a_resp: assert property (p_resp) else $error("response not placed");
  property p_notice; cmd_new_o && hold_code_i == 8'h00 && !(resp_valid_i && resp_ready_o)
    |=> in_field_o[23:16] == 8'hFF && in_field_o[7:0] == cmd_code_o; endproperty
  a_notice: assert property (p_notice) else $error("busy status not posted");
  property p_irq; diag_irq_o |-> $past(diag_irq_en_i); endproperty
  a_irq: assert property (p_irq) else $error("interrupt while disabled");
  // Fault word travels high byte first in the frame
  property p_rsvd; ({diag_frame_o[63:56], diag_frame_o[71:64]} & 16'h9E88) == 16'h0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved fault bit set");
  property p_fixed; up_r == 3'h7 |-> diag_frame_o[55:48] == 8'h2A && diag_frame_o[79:72] == 8'h32;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed frame bytes wrong");
  property p_bad_hold; hold_code_i[2] [*2] |=> !data_exch_o; endproperty
  a_bad_hold: assert property (p_bad_hold) else $error("exchange with bad hold code");
endmodule
bind rfpd_core rfpd_core_checker #(.HOLD_STEP_CYC(HOLD_STEP_CYC)) u_rfpd_core_checker (.clk_i, .nrst_i,
  .hold_code_i, .diag_irq_en_i, .out_valid_i, .out_field_i, .cmd_new_o, .cmd_code_o, .resp_valid_i,
  .resp_ready_o, .resp_status_i, .in_field_o, .data_exch_o, .diag_frame_o, .diag_irq_o);

// ### sim/rfpd_master_model.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Bus master side: writes the output field
module rfpd_master_model (
  // Clock
  input wire logic clk_i,
  // Command request
  input wire logic issue_i,
  input wire logic same_i,
  input wire logic [7:0] code_i,
  input wire logic [31:0] data_i,
  // Output field
  output logic out_valid_o,
  output logic [511:0] out_field_o
);
  logic tog_r; // Toggle flag
  initial begin
    out_valid_o = 1'b0;
    out_field_o = '0;
    tog_r = 1'b0;
  end
  // New field on the falling edge; a plain repeat keeps the toggle
  always @(negedge clk_i) begin
    if (issue_i) begin
      tog_r = tog_r ^ !same_i;
      out_field_o[15:0] = {tog_r, code_i[6:0], code_i};
      out_field_o[31:16] = 16'h0000;
      out_field_o[511:32] = {15{data_i}};
      out_valid_o = 1'b1;
    end
  end
endmodule

// ### sim/rfpd_core_tb.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Self-checking bench for the core
module rfpd_core_tb;
  logic clk_i = 0, nrst_i = 0, rw_mode_i = 1, diag_irq_en_i = 0, tog = 0, nrw = 1;
  logic [2:0] size_code_i = 0, nsz = 0;
  logic [7:0] hold_code_i = 8'h0B, resp_param_i = 0, resp_status_i = 0, code = 0, cnt = 0;
  logic out_valid_i, resp_valid_i = 0, diag_read_i = 0, issue = 0, same = 0;
  logic [15:0] fault_evt_i = 0, head_id_i = 0;
  logic [31:0] data = 0;
  logic [47:0] std_hdr_i = 0, head_sw_i = 0;
  logic [95:0] head_date_i = 0;
  logic [479:0] resp_data_i = '0, cmd_data_o;
  logic [511:0] out_field_i, in_field_o, last = '0;
  logic cmd_new_o, resp_ready_o, data_exch_o, diag_irq_o;
  logic [7:0] cmd_code_o;
  logic [23:0] cmd_param_o;
  logic [3:0] cmd_words_o;
  logic [383:0] diag_frame_o;
  int n_errors = 0, compares = 0, seen, i;
  always #20 clk_i = ~clk_i;
  rfpd_master_model u_rfpd_master_model (.clk_i(clk_i), .issue_i(issue), .same_i(same), .code_i(code),
    .data_i(data), .out_valid_o(out_valid_i), .out_field_o(out_field_i));
  rfpd_core #(.HOLD_STEP_CYC(4)) u_rfpd_core (.clk_i, .nrst_i, .rw_mode_i, .size_code_i, .hold_code_i,
    .diag_irq_en_i, .out_valid_i, .out_field_i, .cmd_new_o, .cmd_code_o, .cmd_param_o, .cmd_data_o,
    .cmd_words_o, .resp_valid_i, .resp_ready_o, .resp_param_i, .resp_status_i, .resp_data_i,
    .in_field_o, .data_exch_o, .fault_evt_i, .diag_read_i, .std_hdr_i, .head_id_i, .head_sw_i,
    .head_date_i, .diag_frame_o, .diag_irq_o);
  ////////////////////////////////////////
  // Compare and count
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Verdict
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Data words carried by the selected module
  function automatic logic [3:0] words(input logic rw, input logic [2:0] sz);
    if (!rw) return 4'h0;
    return (sz == 3'h7) ? 4'hF : {1'b0, sz} + 4'h1;
  endfunction
  // Wait for the input field to change, then check the counter
  task automatic wait_upd;
    for (int k = 0; k < 200 && in_field_o === last; k++) @(negedge clk_i);
    cnt = (cnt == 8'hFF) ? 8'h01 : cnt + 8'h01;
    chk("counter", cnt, in_field_o[31:24]);
    last = in_field_o;
  endtask
  // Send one request and count detections
  task automatic send_count;
    issue <= 1;
    @(negedge clk_i);
    issue <= 0;
    same <= 0;
    seen = 0;
    repeat (12) begin
      @(negedge clk_i);
      if (cmd_new_o === 1) seen++;
    end
  endtask
  // One command with busy notice and final response
  task automatic round;
    issue <= 1;
    tog = ~tog;
    @(negedge clk_i);
    issue <= 0;
    // Module selection changes together with the new field, so a mask change alone is never seen
    rw_mode_i <= nrw;
    size_code_i <= nsz;
    for (seen = 0; seen < 50 && cmd_new_o !== 1; seen++) @(negedge clk_i);
    chk("code", code, cmd_code_o);
    chk("param", {16'h0000, tog, code[6:0]}, cmd_param_o);
    chk("words", words(rw_mode_i, size_code_i), cmd_words_o);
    chk("data", rw_mode_i ? data : 0, cmd_data_o[31:0]);
    chk("tail", (words(rw_mode_i, size_code_i) == 4'hF) ? data : 0, cmd_data_o[479:448]);
    wait_upd;
    chk("notice", {code, 8'hFF}, {in_field_o[7:0], in_field_o[23:16]});
    resp_status_i <= 8'($urandom_range(0, 254));
    resp_param_i <= 8'($urandom);
    resp_data_i <= {15{$urandom}};
    resp_valid_i <= 1;
    for (seen = 0; seen < 200; seen++) begin
      @(posedge clk_i);
      if (resp_ready_o === 1) break;
    end
    @(negedge clk_i);
    resp_valid_i <= 0;
    wait_upd;
    chk("resp", {tog, resp_param_i[6:0], resp_status_i, resp_data_i[31:0]},
      {in_field_o[15:8], in_field_o[23:16], in_field_o[63:32]});
  endtask
  ////////////////////////////////////////
  // Watchdog
  initial begin
    #2000000;
    n_errors++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    void'($urandom(32'hB91B));
    std_hdr_i = {$urandom, 16'h5AA5};
    head_id_i = 16'($urandom);
    head_sw_i = {$urandom, 16'h0F0F};
    head_date_i = {$urandom, $urandom, $urandom};
    repeat (3) @(negedge clk_i);
    nrst_i <= 1;
    repeat (4) @(negedge clk_i);
    // Every module size, long hold first, then random
    for (i = 0; i < 140; i++) begin
      nrw <= (i < 16) ? i[3] : 1'($urandom);
      nsz <= (i < 16) ? i[2:0] : 3'($urandom);
      code <= 8'($urandom);
      data <= $urandom;
      @(negedge clk_i);
      round;
      if (i == 5) begin
        repeat (60) @(negedge clk_i);
        hold_code_i <= 8'h00;
      end
    end
    $display("test commands done");
    // Unchanged field is not a new command
    same <= 1;
    send_count;
    chk("repeat", 0, seen);
    // Fault bits and interrupt gate
    for (i = 0; i < 16; i++) begin
      diag_read_i <= 1;
      @(negedge clk_i);
      diag_read_i <= 0;
      fault_evt_i <= 16'h1 << i;
      diag_irq_en_i <= i[0];
      @(negedge clk_i);
      fault_evt_i <= 0;
      chk("irq", i[0] & 16'h6177 >> i, diag_irq_o);
      @(negedge clk_i);
      chk("fault", 1'(16'h6177 >> i), diag_frame_o[56 + (i ^ 8)]);
    end
    chk("hdr", std_hdr_i, diag_frame_o[47:0]);
    chk("dev", {8'h2A, 8'h32}, {diag_frame_o[55:48], diag_frame_o[79:72]});
    chk("heads", {head_id_i, head_sw_i[23:0]}, {diag_frame_o[311:304], diag_frame_o[231:224],
      diag_frame_o[255:232]});
    chk("hdate", head_date_i[47:0], diag_frame_o[303:256]);
    $display("test diagnostics done");
    // Forbidden hold code stops exchange
    hold_code_i <= 8'h04;
    repeat (4) @(negedge clk_i);
    chk("exch", 0, data_exch_o);
    code <= ~code;
    send_count;
    chk("blocked", 0, seen);
    $display("test bad hold done");
    tally_and_finish;
  end
endmodule
